// ### src/servo_axis_pkg.sv
`default_nettype none
package servo_axis_pkg;

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	localparam int         ADDR_W         = 8;
	localparam int         DATA_W         = 32;
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_SPEED      = 8'h04;
	localparam logic [7:0] OFS_POSITION   = 8'h08;
	localparam logic [7:0] OFS_STATUS     = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_SERVO_ON_BIT     = 0;
	localparam int CTRL_READY_CHK_DIS_BIT = 1;
	localparam int CTRL_REF_ARM_BIT      = 2;
	localparam int CTRL_REF_MODE_LSB     = 4;
	localparam int STATUS_AMP_READY_BIT  = 0;
	localparam int STATUS_ALARM_BIT      = 1;
	localparam int STATUS_DIR_BIT        = 2;
	localparam int STATUS_ENABLE_BIT     = 3;
	localparam int STATUS_READY_OUT_BIT  = 4;
	localparam int STATUS_REF_EST_BIT    = 5;
	localparam int STATUS_VARIANT_BIT    = 6;
	localparam int IRQ_ALARM             = 0;
	localparam int IRQ_READY_LOST        = 1;
	localparam int IRQ_INDEX             = 2;
	localparam int IRQ_REF_DONE          = 3;
	localparam int IRQ_HOST_FAULT        = 4;
	localparam int IRQ_QUAD_ERR          = 5;
	localparam int IRQ_W                 = 6;
	localparam int SPEED_W               = 16;

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [SPEED_W-1:0] SPEED_RESET    = 16'h0000;
	localparam logic [IRQ_W-1:0]   IRQ_MASK_RESET = 6'h00;
	localparam logic [DATA_W-1:0]  POS_RESET      = 32'h0000_0000;
	localparam int                 STALL_CYCLES_DEFAULT = 1000;
	localparam int                 STALL_CNT_W    = 16;
	localparam logic               VARIANT_M      = 1'b1;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		REF_BY_INDEX,
		REF_BY_EXTERNAL,
		REF_BY_BUTT_STOP,
		REF_UNUSED
	} ref_mode_type;

	typedef struct packed {
		ref_mode_type ref_mode;
		logic         ref_arm;
		logic         ready_check_disable;
		logic         servo_on;
	} ctrl_type;

	typedef struct packed {
		logic overload_alarm_in;
		logic amp_ready_f_n;
		logic amp_ready_m_n;
		logic amp_alarm_in;
		logic phase_a;
		logic phase_b;
		logic phase_z;
		logic ref_trigger;
		logic interface_variant_select;
	} pin_in_type;

	localparam int PIN_W = $bits(pin_in_type);

	typedef enum logic [1:0] {
		AXIS_IDLE,
		AXIS_WAIT_READY,
		AXIS_RUN,
		AXIS_FAULT
	} axis_state_type;

endpackage
`default_nettype wire

// ### src/input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module input_sync
	import servo_axis_pkg::*;
#(
	parameter int WIDTH = PIN_W
)(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] stage1_r;

	// two flip-flop synchroniser
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			stage1_r <= '0;
			q        <= '0;
		end
		else
		begin
			stage1_r <= d;
			q        <= stage1_r;
		end
	end

	property p_sync_delay;
		@(posedge clk_sys) disable iff (rst)
		(!$past(rst) && !$past(rst, 2)) |-> (q == $past(d, 2));
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("synchroniser delay is not two cycles");

endmodule // input_sync
`default_nettype wire

// ### src/analog_servo_axis_interface.sv
`timescale 1ns/1ps
`default_nettype none
module analog_servo_axis_interface
	import servo_axis_pkg::*;
#(
	parameter int STALL_CYCLES = STALL_CYCLES_DEFAULT
)(
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic [ADDR_W-1:0]  bus_addr,
	input  wire logic [DATA_W-1:0]  bus_wdata,
	input  wire logic               bus_we,
	input  wire logic               bus_re,
	output var  logic [DATA_W-1:0]  bus_rdata,
	output var  logic               irq,
	input  wire logic               overload_alarm_in,
	input  wire logic               amp_ready_f_n,
	input  wire logic               amp_ready_m_n,
	input  wire logic               amp_alarm_in,
	input  wire logic               phase_a,
	input  wire logic               phase_b,
	input  wire logic               phase_z,
	input  wire logic               ref_trigger,
	input  wire logic               interface_variant_select,
	input  wire logic               host_system_alarm,
	input  wire logic               host_link_lost,
	output var  logic               amp_enable_n_out,
	output var  logic               amp_enable_n_oe,
	output var  logic               controller_ready_n_out,
	output var  logic               controller_ready_n_oe,
	output var  logic [SPEED_W-1:0] speed_command
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	pin_in_type              pins_raw;
	pin_in_type              pins_s;
	ctrl_type                ctrl_r;
	logic [SPEED_W-1:0]      speed_r;
	logic [DATA_W-1:0]       pos_r;
	logic [IRQ_W-1:0]        irq_status_r;
	logic [IRQ_W-1:0]        irq_status_nxt;
	logic [IRQ_W-1:0]        irq_mask_r;
	logic [IRQ_W-1:0]        irq_event;
	axis_state_type          state_r;
	axis_state_type          state_nxt;
	logic [1:0]              ab_prev_r;
	logic                    z_prev_r;
	logic                    trig_prev_r;
	logic                    alarm_prev_r;
	logic                    dir_r;
	logic                    ref_est_r;
	logic [STALL_CNT_W-1:0]  stall_cnt_r;
	logic [1:0]              step;
	logic                    alarm_now;
	logic                    amp_ready;
	logic                    ready_ok;
	logic                    host_fault;
	logic                    z_rise;
	logic                    trig_rise;
	logic                    stall_done;
	logic                    ref_event;
	logic                    fault_entry;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a,
	                             input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// step code: 01 up, 10 down, 11 illegal jump, 00 none
	function automatic logic [1:0] quad_step(input logic [1:0] prev,
	                                         input logic [1:0] cur);
		logic [1:0] r;
		r = 2'h0;
		case ({prev, cur})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'h1;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: r = 2'h2;
			4'b0011, 4'b1100, 4'b0110, 4'b1001: r = 2'h3;
			default: r = 2'h0;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	assign pins_raw = '{
		overload_alarm_in:        overload_alarm_in,
		amp_ready_f_n:            amp_ready_f_n,
		amp_ready_m_n:            amp_ready_m_n,
		amp_alarm_in:             amp_alarm_in,
		phase_a:                  phase_a,
		phase_b:                  phase_b,
		phase_z:                  phase_z,
		ref_trigger:              ref_trigger,
		interface_variant_select: interface_variant_select
	};

	input_sync #(
		.WIDTH (PIN_W)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       (pins_raw),
		.q       (pins_s)
	);

	// ------------------------------------------------------------
	// amplifier status evaluation
	// ------------------------------------------------------------
	// high level, which a released line also reads as, is alarm
	assign alarm_now = (pins_s.interface_variant_select == VARIANT_M)
		? pins_s.amp_alarm_in
		: pins_s.overload_alarm_in;
	assign amp_ready = (pins_s.interface_variant_select == VARIANT_M)
		? !pins_s.amp_ready_m_n
		: !pins_s.amp_ready_f_n;
	assign ready_ok   = amp_ready || ctrl_r.ready_check_disable;
	assign host_fault = host_system_alarm || host_link_lost;

	// ------------------------------------------------------------
	// axis sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			AXIS_IDLE:
				if (ctrl_r.servo_on && !alarm_now && !host_fault)
					state_nxt = AXIS_WAIT_READY;
			AXIS_WAIT_READY:
				if (alarm_now || host_fault)
					state_nxt = AXIS_FAULT;
				else if (!ctrl_r.servo_on)
					state_nxt = AXIS_IDLE;
				else if (ready_ok)
					state_nxt = AXIS_RUN;
			AXIS_RUN:
				if (alarm_now || host_fault || !ready_ok)
					state_nxt = AXIS_FAULT;
				else if (!ctrl_r.servo_on)
					state_nxt = AXIS_IDLE;
			AXIS_FAULT:
				if (!ctrl_r.servo_on)
					state_nxt = AXIS_IDLE;
		endcase
	end

	assign fault_entry = (state_nxt == AXIS_FAULT) &&
	                     (state_r != AXIS_FAULT);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_r <= AXIS_IDLE;
		else
			state_r <= state_nxt;
	end

	// open collector outputs: drive low only when asserted
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			amp_enable_n_out       <= 1'b0;
			amp_enable_n_oe        <= 1'b0;
			controller_ready_n_out <= 1'b0;
			controller_ready_n_oe  <= 1'b0;
			speed_command          <= SPEED_RESET;
		end
		else
		begin
			amp_enable_n_out       <= 1'b0;
			amp_enable_n_oe        <= (state_nxt == AXIS_RUN);
			controller_ready_n_out <= 1'b0;
			controller_ready_n_oe  <= (state_nxt == AXIS_WAIT_READY) ||
			                          (state_nxt == AXIS_RUN);
			speed_command          <= (state_nxt == AXIS_RUN)
			                          ? speed_r : SPEED_RESET;
		end
	end

	// ------------------------------------------------------------
	// quadrature decoding and reference setting
	// ------------------------------------------------------------
	assign step      = quad_step(ab_prev_r,
	                             {pins_s.phase_a, pins_s.phase_b});
	assign z_rise    = pins_s.phase_z && !z_prev_r;
	assign trig_rise = pins_s.ref_trigger && !trig_prev_r;
	assign stall_done = (stall_cnt_r == STALL_CNT_W'(STALL_CYCLES - 1));

	always_comb
	begin
		ref_event = 1'b0;
		if (ctrl_r.ref_arm)
		begin
			unique case (ctrl_r.ref_mode)
				REF_BY_INDEX:     ref_event = z_rise;
				REF_BY_EXTERNAL:  ref_event = trig_rise;
				REF_BY_BUTT_STOP: ref_event = stall_done;
				REF_UNUSED:       ref_event = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ab_prev_r   <= 2'h0;
			z_prev_r    <= 1'b0;
			trig_prev_r <= 1'b0;
		end
		else
		begin
			ab_prev_r   <= {pins_s.phase_a, pins_s.phase_b};
			z_prev_r    <= pins_s.phase_z;
			trig_prev_r <= pins_s.ref_trigger;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pos_r <= POS_RESET;
			dir_r <= 1'b0;
		end
		else
		begin
			if (ref_event)
				pos_r <= POS_RESET;
			else if (step == 2'h1)
				pos_r <= pos_r + 32'h0000_0001;
			else if (step == 2'h2)
				pos_r <= pos_r - 32'h0000_0001;
			if (step == 2'h1)
				dir_r <= 1'b0;
			else if (step == 2'h2)
				dir_r <= 1'b1;
		end
	end

	// butt stop: axis running but no feedback movement
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			stall_cnt_r <= '0;
		else if (state_r != AXIS_RUN || step != 2'h0 || stall_done ||
		         ctrl_r.ref_mode != REF_BY_BUTT_STOP || !ctrl_r.ref_arm)
			stall_cnt_r <= '0;
		else
			stall_cnt_r <= stall_cnt_r + STALL_CNT_W'(1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ref_est_r <= 1'b0;
		else if (ref_event)
			ref_est_r <= 1'b1;
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_r     <= '0;
			speed_r    <= SPEED_RESET;
			irq_mask_r <= IRQ_MASK_RESET;
		end
		else
		begin
			if (bus_we && hit(bus_addr, OFS_CTRL))
			begin
				ctrl_r.servo_on            <= bus_wdata[CTRL_SERVO_ON_BIT];
				ctrl_r.ready_check_disable <=
					bus_wdata[CTRL_READY_CHK_DIS_BIT];
				ctrl_r.ref_arm             <= bus_wdata[CTRL_REF_ARM_BIT];
				ctrl_r.ref_mode            <= ref_mode_type'(
					bus_wdata[CTRL_REF_MODE_LSB +: 2]);
			end
			else if (ref_event)
				ctrl_r.ref_arm <= 1'b0;
			if (bus_we && hit(bus_addr, OFS_SPEED))
				speed_r <= bus_wdata[SPEED_W-1:0];
			if (bus_we && hit(bus_addr, OFS_IRQ_MASK))
				irq_mask_r <= bus_wdata[IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	always_comb
	begin
		irq_event                 = '0;
		irq_event[IRQ_ALARM]      = alarm_now && !alarm_prev_r;
		irq_event[IRQ_READY_LOST] = fault_entry && !ready_ok &&
		                            (state_r == AXIS_RUN);
		irq_event[IRQ_INDEX]      = z_rise;
		irq_event[IRQ_REF_DONE]   = ref_event;
		irq_event[IRQ_HOST_FAULT] = fault_entry && host_fault;
		irq_event[IRQ_QUAD_ERR]   = (step == 2'h3);
	end

	// new events win over a same-cycle clear
	always_comb
	begin
		irq_status_nxt = irq_status_r;
		if (bus_we && hit(bus_addr, OFS_IRQ_STATUS))
			irq_status_nxt = irq_status_nxt & ~bus_wdata[IRQ_W-1:0];
		irq_status_nxt = irq_status_nxt | irq_event;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			irq_status_r <= '0;
			alarm_prev_r <= 1'b0;
			irq          <= 1'b0;
		end
		else
		begin
			irq_status_r <= irq_status_nxt;
			alarm_prev_r <= alarm_now;
			irq          <= |(irq_status_nxt & irq_mask_r);
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			bus_rdata <= '0;
		else if (!bus_re)
			bus_rdata <= '0;
		else
		begin
			bus_rdata <= '0;
			if (hit(bus_addr, OFS_CTRL))
				bus_rdata <= {26'h0, ctrl_r.ref_mode, 1'b0,
				              ctrl_r.ref_arm, ctrl_r.ready_check_disable,
				              ctrl_r.servo_on};
			if (hit(bus_addr, OFS_SPEED))
				bus_rdata <= {16'h0, speed_r};
			if (hit(bus_addr, OFS_POSITION))
				bus_rdata <= pos_r;
			if (hit(bus_addr, OFS_STATUS))
				bus_rdata <= {25'h0, pins_s.interface_variant_select,
				              ref_est_r, controller_ready_n_oe,
				              amp_enable_n_oe, dir_r, alarm_now, amp_ready};
			if (hit(bus_addr, OFS_IRQ_STATUS))
				bus_rdata <= {26'h0, irq_status_r};
			if (hit(bus_addr, OFS_IRQ_MASK))
				bus_rdata <= {26'h0, irq_mask_r};
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_cmd_only_enabled;
		@(posedge clk_sys) disable iff (rst)
		(speed_command != SPEED_RESET) |-> amp_enable_n_oe;
	endproperty
	a_cmd_only_enabled: assert property (p_cmd_only_enabled)
		else $error("speed command active without enable");

	property p_open_collector;
		@(posedge clk_sys) disable iff (rst)
		!amp_enable_n_out && (!amp_enable_n_oe || controller_ready_n_oe);
	endproperty
	a_open_collector: assert property (p_open_collector)
		else $error("enable pin drives high or runs without ready");

	property p_overload_drops;
		@(posedge clk_sys) disable iff (rst)
		(pins_s.interface_variant_select != VARIANT_M &&
		 pins_s.overload_alarm_in) |=>
		!amp_enable_n_oe && !controller_ready_n_oe;
	endproperty
	a_overload_drops: assert property (p_overload_drops)
		else $error("overload did not drop enable and ready");

	property p_ready_lost;
		@(posedge clk_sys) disable iff (rst)
		(state_r == AXIS_RUN && !ctrl_r.ready_check_disable &&
		 pins_s.interface_variant_select != VARIANT_M &&
		 pins_s.amp_ready_f_n) |=>
		(state_r == AXIS_FAULT) && irq_status_r[IRQ_READY_LOST];
	endproperty
	a_ready_lost: assert property (p_ready_lost)
		else $error("released ready line not treated as error");

	property p_check_disable;
		@(posedge clk_sys) disable iff (rst)
		(state_r == AXIS_WAIT_READY && ctrl_r.ready_check_disable &&
		 ctrl_r.servo_on && !alarm_now && !host_fault) |=>
		amp_enable_n_oe;
	endproperty
	a_check_disable: assert property (p_check_disable)
		else $error("ready check disable did not start the axis");

	property p_count_up;
		@(posedge clk_sys) disable iff (rst)
		(step == 2'h1 && !ref_event) |=> (pos_r == $past(pos_r) + 1);
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("position did not count up on B leading");

	property p_count_down;
		@(posedge clk_sys) disable iff (rst)
		(step == 2'h2 && !ref_event) |=> (pos_r == $past(pos_r) - 1);
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("position did not count down on A leading");

	property p_ext_ref;
		@(posedge clk_sys) disable iff (rst)
		(ctrl_r.ref_arm && ctrl_r.ref_mode == REF_BY_EXTERNAL &&
		 trig_rise) |=> (pos_r == POS_RESET) && ref_est_r &&
		!ctrl_r.ref_arm;
	endproperty
	a_ext_ref: assert property (p_ext_ref)
		else $error("external trigger did not set reference");

	property p_alarm_m;
		@(posedge clk_sys) disable iff (rst)
		(pins_s.interface_variant_select == VARIANT_M &&
		 pins_s.amp_alarm_in) |=> !amp_enable_n_oe ##1 !amp_enable_n_oe;
	endproperty
	a_alarm_m: assert property (p_alarm_m)
		else $error("variant M alarm did not hold enable off");

	property p_ready_m;
		@(posedge clk_sys) disable iff (rst)
		(pins_s.interface_variant_select == VARIANT_M &&
		 !ctrl_r.ready_check_disable && pins_s.amp_ready_m_n) |=>
		(state_r != AXIS_RUN);
	endproperty
	a_ready_m: assert property (p_ready_m)
		else $error("variant M ran while ready input high");

	property p_host_fault;
		@(posedge clk_sys) disable iff (rst)
		host_fault |=> !amp_enable_n_oe && !controller_ready_n_oe;
	endproperty
	a_host_fault: assert property (p_host_fault)
		else $error("host fault did not drop enable and ready");

	c_run: cover property (@(posedge clk_sys) disable iff (rst)
		state_r == AXIS_WAIT_READY ##1 state_r == AXIS_RUN);
	c_fault: cover property (@(posedge clk_sys) disable iff (rst)
		state_r == AXIS_RUN ##1 state_r == AXIS_FAULT);
	c_ref_done: cover property (@(posedge clk_sys) disable iff (rst)
		ref_event);
	c_irq: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(irq));

endmodule // analog_servo_axis_interface
`default_nettype wire

// ### verification/servo_amp_model.sv
`timescale 1ns/1ps
`default_nettype none
module servo_amp_model (
	input  wire logic clk_sys,
	input  wire logic ctl_ready_n,
	input  wire logic enable_n,
	input  wire logic err,
	input  wire logic ovld,
	input  wire logic alarm,
	input  wire logic step,
	input  wire logic dir,
	output var  logic amp_ready_f_n,
	output var  logic amp_ready_m_n,
	output var  logic overload_alarm_in,
	output var  logic amp_alarm_in,
	output var  logic phase_a,
	output var  logic phase_b,
	output var  logic phase_z
);
	// ----------------------------------------
	// amplifier status lines
	// ----------------------------------------
	logic [1:0] q_r = 2'h0;
	logic [3:0] n_r = 4'h0;
	assign amp_ready_f_n     = ctl_ready_n | err;
	assign amp_ready_m_n     = ctl_ready_n | err;
	assign overload_alarm_in = ovld;
	assign amp_alarm_in      = alarm;
	// ----------------------------------------
	// encoder, moves only when enabled
	// ----------------------------------------
	always_ff @(posedge clk_sys)
		if (step && !enable_n && !(ovld || alarm || err))
		begin
			q_r <= dir ? q_r - 2'h1 : q_r + 2'h1;
			n_r <= n_r + 4'h1;
		end
	assign phase_a = q_r[1];
	assign phase_b = q_r[1] ^ q_r[0];
	assign phase_z = (n_r == 4'h0);
endmodule // servo_amp_model
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import servo_axis_pkg::*;
	logic              clk_sys = 1'b0;
	logic              rst     = 1'b1;
	logic [7:0]        bus_addr = 8'h00;
	logic [31:0]       bus_wdata = 32'h0;
	logic [31:0]       bus_rdata, spd;
	logic              bus_we = 1'b0, bus_re = 1'b0, irq;
	logic              err = 1'b0, ovld = 1'b0, alarm = 1'b0, step = 1'b0;
	logic              dir = 1'b0, ref_t = 1'b0, vsel = 1'b0;
	logic              h_alarm = 1'b0, h_lost = 1'b0;
	logic              ovld_p, rf_n, rm_n, alarm_p, pa, pb, pz;
	logic              en_out, en_oe, rdy_out, rdy_oe, en_wire, rdy_wire;
	logic [15:0]       speed_command;
	int                fail_count = 0, checked = 0, seed = 76, cyc = 0, t = 0, k;
	always #10 clk_sys = ~clk_sys;
	assign en_wire  = en_oe ? en_out : 1'b1;
	assign rdy_wire = rdy_oe ? rdy_out : 1'b1;
	analog_servo_axis_interface #(.STALL_CYCLES(8)) u_dut (.clk_sys(clk_sys),
		.rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
		.bus_re(bus_re), .bus_rdata(bus_rdata), .irq(irq),
		.overload_alarm_in(ovld_p), .amp_ready_f_n(rf_n), .amp_ready_m_n(rm_n),
		.amp_alarm_in(alarm_p), .phase_a(pa), .phase_b(pb), .phase_z(pz),
		.ref_trigger(ref_t), .interface_variant_select(vsel),
		.host_system_alarm(h_alarm), .host_link_lost(h_lost),
		.amp_enable_n_out(en_out), .amp_enable_n_oe(en_oe),
		.controller_ready_n_out(rdy_out), .controller_ready_n_oe(rdy_oe),
		.speed_command(speed_command));
	servo_amp_model u_amp (.clk_sys(clk_sys), .ctl_ready_n(rdy_wire),
		.enable_n(en_wire), .err(err), .ovld(ovld), .alarm(alarm),
		.step(step), .dir(dir), .amp_ready_f_n(rf_n), .amp_ready_m_n(rm_n),
		.overload_alarm_in(ovld_p), .amp_alarm_in(alarm_p), .phase_a(pa),
		.phase_b(pb), .phase_z(pz));
	// ----------------------------------------
	// compare, bus and pin tasks
	// ----------------------------------------
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_we    <= 1'b1;
		@(posedge clk_sys);
		bus_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_re   <= 1'b1;
		@(posedge clk_sys);
		bus_re <= 1'b0;
		#1 chk32(bus_rdata, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pins(input logic e, input logic r);
		chk1(en_oe, e);
		chk1(rdy_oe, r);
	endtask
	task automatic move(input logic d, input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			dir  <= d;
			step <= 1'b1;
			@(posedge clk_sys);
			step <= 1'b0;
			wt(6);
		end
	endtask
	task automatic fin;
		t++;
		$display("test %0d done", t);
	endtask
	task close_out;
		$display("counts: %0d checked, %0d wrong", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			close_out;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		wt(4);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_IRQ_MASK, 32'h0);
		rd(8'h20, 32'h0);
		pins(1'b0, 1'b0);
		spd = $random(seed) & 32'hffff;
		wr(OFS_SPEED, spd);
		#1 chk32({16'h0, speed_command}, 32'h0);
		wr(OFS_CTRL, 32'h1);
		wt(6);
		pins(1'b1, 1'b1);
		chk1(en_wire, 1'b0);
		chk32({16'h0, speed_command}, spd);
		fin;
		k = 3 + ($random(seed) & 7);
		move(1'b0, k);
		rd(OFS_POSITION, k);
		move(1'b1, k + 2);
		rd(OFS_POSITION, 32'hffff_fffe);
		fin;
		wr(OFS_CTRL, 32'h15);
		@(posedge clk_sys) ref_t <= 1'b1;
		wt(4);
		@(posedge clk_sys) ref_t <= 1'b0;
		wt(4);
		rd(OFS_POSITION, 32'h0);
		move(1'b0, 2);
		wr(OFS_CTRL, 32'h25);
		wt(20);
		rd(OFS_POSITION, 32'h0);
		wr(OFS_CTRL, 32'h5);
		move(1'b0, 16);
		rd(OFS_POSITION, (2 * k + 4) % 16);
		fin;
		wr(OFS_IRQ_STATUS, 32'h3f);
		@(posedge clk_sys) ovld <= 1'b1;
		wt(6);
		pins(1'b0, 1'b0);
		chk1(irq, 1'b0);
		wr(OFS_IRQ_MASK, 32'h1);
		wt(2);
		chk1(irq, 1'b1);
		@(posedge clk_sys) ovld <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_STATUS, 32'h1);
		wt(2);
		chk1(irq, 1'b0);
		wr(OFS_CTRL, 32'h1);
		wt(6);
		@(posedge clk_sys) err <= 1'b1;
		wt(6);
		pins(1'b0, 1'b0);
		rd(OFS_IRQ_STATUS, 32'h2);
		@(posedge clk_sys) err <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		fin;
		for (k = 0; k < 2; k++)
		begin
			wr(OFS_CTRL, 32'h1);
			wt(6);
			@(posedge clk_sys) {h_lost, h_alarm} <= k[0] ? 2'h2 : 2'h1;
			wt(3);
			pins(1'b0, 1'b0);
			@(posedge clk_sys) {h_lost, h_alarm} <= 2'h0;
			wr(OFS_CTRL, 32'h0);
		end
		fin;
		@(posedge clk_sys) {vsel, err, ovld} <= 3'h7;
		wt(4);
		wr(OFS_CTRL, 32'h1);
		wt(6);
		pins(1'b0, 1'b1);
		wr(OFS_CTRL, 32'h3);
		wt(4);
		pins(1'b1, 1'b1);
		rd(OFS_STATUS, 32'h78);
		@(posedge clk_sys) alarm <= 1'b1;
		wt(6);
		pins(1'b0, 1'b0);
		fin;
		close_out;
	end
endmodule // testbench
`default_nettype wire
